// >>> logic/ssd_debounce.sv
// Synchroniser and debouncer for a group of switch contacts.
// Assumes asynchronous, bouncing inputs; output moves only after a steady reading.
`timescale 1ns/1ns
module ssd_debounce #(
   parameter int W = 9,
   parameter int STABLE_CYCLES = 500000
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] raw_i,
   output logic [W-1:0] stable_o
);
   import ssd_pkg::*;

   logic [W-1:0] meta_q, sync_q, cand_q, cand_d, stable_q, stable_d;
   logic [DBC_W-1:0] cnt_q, cnt_d;
   localparam logic [DBC_W-1:0] LAST = DBC_W'(STABLE_CYCLES - 1);

   // Restart the count on any change; accept after a full steady window
   always_comb begin
      cand_d = cand_q;
      cnt_d = cnt_q;
      stable_d = stable_q;
      if (sync_q != cand_q) begin
         cand_d = sync_q;
         cnt_d = '0;
      end else if (cnt_q >= LAST) begin
         stable_d = cand_q;
      end else begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   // First stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
         cand_q <= '0;
         cnt_q <= '0;
         stable_q <= '0;
      end else begin
         meta_q <= raw_i;
         sync_q <= meta_q;
         cand_q <= cand_d;
         cnt_q <= cnt_d;
         stable_q <= stable_d;
      end
   end

   assign stable_o = stable_q;
endmodule

// >>> logic/ssd_line_table.sv
// Maps a rotary position to an emulated encoder line count.
// Assumes the position is already limited to 0..9.
`timescale 1ns/1ns
module ssd_line_table (
   input wire logic [ssd_pkg::ROT_W-1:0] rot_pos_i,
   input wire logic [ssd_pkg::LINE_W-1:0] stored_i,
   output logic [ssd_pkg::LINE_W-1:0] lines_o
);
   import ssd_pkg::*;

   // Position 0 takes the stored count, others the fixed table
   always_comb begin
      lines_o = stored_i;
      if (rot_pos_i != ROT_POS_STORED && rot_pos_i < ROT_POSITIONS) begin
         lines_o = ROT_LINES[rot_pos_i];
      end
   end
endmodule

// >>> logic/ssd_pkg.sv
// Constants, register map and lookup helpers for the setup switch decoder.
// Assumes a single 50 MHz clock and an AHB-Lite register port.
package ssd_pkg;

   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int DEBOUNCE_TIME_US = 10000;
   localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DBC_W = 20;

   // Widths
   localparam int DIP_W = 4;
   localparam int ROT_W = 4;
   localparam int LINE_W = 16;
   localparam int GAIN_W = 16;
   localparam int SW_W = DIP_W + ROT_W + 1;

   // Switch layout
   localparam int DIP_POS_MODE = 0;
   localparam int DIP_POS_FB = 1;
   localparam logic [ROT_W-1:0] ROT_POSITIONS = 4'ha;
   localparam logic [ROT_W-1:0] ROT_POS_STORED = 4'h0;

   // Parameter encodings
   localparam logic [1:0] PARAM_FOLLOW = 2'h0;
   localparam logic [1:0] MODE_TORQUE = 2'h1;
   localparam logic [1:0] MODE_VELOCITY = 2'h2;
   localparam logic [1:0] FB_SMART = 2'h1;
   localparam logic [1:0] FB_SIXSTEP = 2'h2;

   // Register byte addresses
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_LINECNT = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_GAIN = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_LINES = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_KIP = 8'h14;

   // Field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_FB_LSB = 2;
   localparam int ST_DIP_LSB = 0;
   localparam int ST_ROT_LSB = 4;
   localparam int ST_TORQUE = 8;
   localparam int ST_SMART = 9;
   localparam int ST_EMUL = 10;
   localparam int ST_REJECT = 11;
   localparam int ST_HIRES = 12;
   localparam int KIP_STORE_BIT = 16;

   // Reset values
   localparam logic [LINE_W-1:0] LINECNT_RST = 16'h01f4;
   localparam logic [GAIN_W-1:0] GAIN_RST = 16'h0100;

   // Line counts chosen by rotary positions 1 to 9
   localparam logic [LINE_W-1:0] ROT_LINES [1:9] = '{16'h0200, 16'h03e8, 16'h0400, 16'h07d0, 16'h0800,
                                                      16'h1000, 16'h1388, 16'h2000, 16'h2710};

   // Line counts accepted by the stored parameter
   localparam logic [LINE_W-1:0] VALID_LINES [0:15] = '{16'h0080, 16'h0200, 16'h0400, 16'h0800,
                                                         16'h1000, 16'h2000, 16'h4000, 16'h8000,
                                                         16'h007d, 16'h01f4, 16'h03e8, 16'h07d0,
                                                         16'h09c4, 16'h1388, 16'h2710, 16'h4e20};

   // Bus slave states
   typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} ssd_bus_e;

   // True when a value is one of the accepted stored line counts
   function automatic logic line_count_valid(input logic [LINE_W-1:0] v);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (v == VALID_LINES[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // A parameter either follows its switch or forces a choice
   function automatic logic pick(input logic [1:0] param, input logic [1:0] force_code, input logic sw);
      return (param == PARAM_FOLLOW) ? sw : (param == force_code);
   endfunction

endpackage

// >>> logic/ssd_top.sv
// Setup switch decoder: turns the mode DIP and setup rotary switches into drive settings.
// Assumes one 50 MHz clock, asynchronous switch pins and an AHB-Lite master for parameters.
//
// Overview of operation
// - Four-position DIP; only positions one and two matter, when enabled.
// - Position one closed gives torque/current control, open gives velocity control.
// - Position two closed gives smart feedback, open gives 6-step Hall feedback.
// - Positions three and four are reserved and ignored; installer leaves them closed.
// - Each selection follows its switch only while its parameter holds follow-switch.
// - Ten-position rotary switch; meaning depends on the feedback mode.
// - Smart feedback: positions 1-9 pick 512 up to 10000 lines per revolution.
// - Smart feedback: position 0 uses the stored line count, default 500.
// - Stored line count accepts only the sixteen listed values.
// - Emulated output only with smart feedback or a high-resolution option card.
// - 6-step mode: rotary picks current loop gain; position 0 uses stored gain.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
module ssd_top #(
   parameter int DEBOUNCE_CYCLES = ssd_pkg::DEBOUNCE_CYCLES
) (
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   input wire logic [ssd_pkg::DIP_W-1:0] MODE_DIP_SWITCH_I,
   input wire logic [ssd_pkg::ROT_W-1:0] SETUP_ROTARY_SWITCH_I,
   input wire logic HIRES_OPTION_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   output logic [31:0] HRDATA_O,
   output logic TORQUE_MODE_O,
   output logic SMART_FEEDBACK_O,
   output logic EMUL_ENABLE_O,
   output logic [ssd_pkg::LINE_W-1:0] EMUL_LINES_O,
   output logic [ssd_pkg::ROT_W-1:0] GAIN_POS_O,
   output logic GAIN_FROM_STORE_O,
   output logic [ssd_pkg::GAIN_W-1:0] CURRENT_LOOP_GAIN_O
);
   import ssd_pkg::*;

   // Reset release synchroniser: assertion is immediate, release waits two edges
   // so no flop leaves reset on a metastable input
   logic rst_meta_q, rst_n;
   always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // Switch conditioning; a pin at 1 means the contact is closed (down)
   // One window serves every contact, so a move on any switch restarts the count for all
   logic [SW_W-1:0] sw_stable;
   logic [DIP_W-1:0] dip;
   logic [ROT_W-1:0] rot_raw;
   logic hires;
   ssd_debounce #(
      .W(SW_W),
      .STABLE_CYCLES(DEBOUNCE_CYCLES)
   ) u_debounce (
      .clk_i(REF_CLK_I),
      .rst_n_i(rst_n),
      .raw_i({HIRES_OPTION_I, SETUP_ROTARY_SWITCH_I, MODE_DIP_SWITCH_I}),
      .stable_o(sw_stable)
   );
   assign dip = sw_stable[DIP_W-1:0];
   assign rot_raw = sw_stable[DIP_W +: ROT_W];
   assign hires = sw_stable[SW_W-1];

   // Parameter registers written over the bus
   logic [1:0] mode_param_q;
   logic [1:0] mode_param_d;
   logic [1:0] fb_param_q;
   logic [1:0] fb_param_d;
   logic [LINE_W-1:0] linecnt_q;
   logic [LINE_W-1:0] linecnt_d;
   logic [GAIN_W-1:0] gain_q;
   logic [GAIN_W-1:0] gain_d;
   logic reject_q;
   logic reject_d;

   // Bus slave state
   ssd_bus_e bus_q;
   ssd_bus_e bus_d;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic accept;

   // Decoded settings
   logic [ROT_W-1:0] rot_q;
   logic [ROT_W-1:0] rot_d;
   logic torque_q;
   logic torque_d;
   logic smart_q;
   logic smart_d;
   logic emul_q;
   logic emul_d;
   logic store_q;
   logic store_d;
   logic [LINE_W-1:0] lines_q;
   logic [LINE_W-1:0] lines_d;
   logic [LINE_W-1:0] table_lines;
   logic [ROT_W-1:0] gpos_q;
   logic [ROT_W-1:0] gpos_d;
   logic [GAIN_W-1:0] gout_q;
   logic [GAIN_W-1:0] gout_d;

   ssd_line_table u_line_table (
      .rot_pos_i(rot_q),
      .stored_i(linecnt_q),
      .lines_o(table_lines)
   );

   // Decode: positions three and four reach only the status read; the decode uses positions one and two
   always_comb begin
      rot_d = rot_q;
      if (rot_raw < ROT_POSITIONS) begin
         rot_d = rot_raw;
      end
      torque_d = pick(mode_param_q, MODE_TORQUE, dip[DIP_POS_MODE]);
      smart_d = pick(fb_param_q, FB_SMART, dip[DIP_POS_FB]);
   end

   // Decode flops
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         rot_q <= '0;
         torque_q <= 1'b0;
         smart_q <= 1'b0;
      end else begin
         rot_q <= rot_d;
         torque_q <= torque_d;
         smart_q <= smart_d;
      end
   end

   // Settings derived from the decode, one cycle behind it, so a feedback change
   // reaches the emulation and gain outputs one edge after SMART_FEEDBACK_O
   always_comb begin
      emul_d = smart_q | hires;
      lines_d = table_lines;
      gpos_d = smart_q ? ROT_POS_STORED : rot_q;
      store_d = !smart_q && (rot_q == ROT_POS_STORED);
      gout_d = store_d ? gain_q : '0;
   end

   // Derived setting flops
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         emul_q <= 1'b0;
         lines_q <= '0;
         gpos_q <= '0;
         store_q <= 1'b0;
         gout_q <= '0;
      end else begin
         emul_q <= emul_d;
         lines_q <= lines_d;
         gpos_q <= gpos_d;
         store_q <= store_d;
         gout_q <= gout_d;
      end
   end

   // Bus: writes take effect in the data phase; reads insert one wait state
   // so a read straight after a write sees the new value from a flop
   assign accept = HSEL_I && HTRANS_I[1] && HREADY_I;

   // Transfer tracking: a wait cycle always follows a read address phase
   always_comb begin
      bus_d = bus_q;
      addr_d = addr_q;
      case (bus_q)
         BUS_READ_WAIT: bus_d = BUS_READ_DONE;
         BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
            if (accept) begin
               addr_d = HADDR_I[ADDR_W-1:0];
               bus_d = HWRITE_I ? BUS_WRITE : BUS_READ_WAIT;
            end else begin
               bus_d = BUS_IDLE;
            end
         end
         default: bus_d = BUS_IDLE;
      endcase
   end

   // Transfer state flops
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         bus_q <= BUS_IDLE;
         addr_q <= '0;
      end else begin
         bus_q <= bus_d;
         addr_q <= addr_d;
      end
   end

   // Parameter writes use the data phase's word; a refused line count keeps the old one
   always_comb begin
      mode_param_d = mode_param_q;
      fb_param_d = fb_param_q;
      linecnt_d = linecnt_q;
      gain_d = gain_q;
      reject_d = reject_q;
      if (bus_q == BUS_WRITE) begin
         case (addr_q)
            ADDR_CTRL: begin
               mode_param_d = HWDATA_I[CTRL_MODE_LSB +: 2];
               fb_param_d = HWDATA_I[CTRL_FB_LSB +: 2];
            end
            ADDR_LINECNT: begin
               if (line_count_valid(HWDATA_I[LINE_W-1:0])) begin
                  linecnt_d = HWDATA_I[LINE_W-1:0];
                  reject_d = 1'b0;
               end else begin
                  reject_d = 1'b1;
               end
            end
            ADDR_GAIN: begin
               gain_d = HWDATA_I[GAIN_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Parameter flops; reset leaves both selections following their switches
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         mode_param_q <= PARAM_FOLLOW;
         fb_param_q <= PARAM_FOLLOW;
         linecnt_q <= LINECNT_RST;
         gain_q <= GAIN_RST;
         reject_q <= 1'b0;
      end else begin
         mode_param_q <= mode_param_d;
         fb_param_q <= fb_param_d;
         linecnt_q <= linecnt_d;
         gain_q <= gain_d;
         reject_q <= reject_d;
      end
   end

   // Read data is taken in the wait cycle, so HRDATA_O comes from a flop and holds until the next read
   always_comb begin
      rdata_d = rdata_q;
      if (bus_q == BUS_READ_WAIT) begin
         rdata_d = '0;
         case (addr_q)
            ADDR_CTRL: begin
               rdata_d[CTRL_MODE_LSB +: 2] = mode_param_q;
               rdata_d[CTRL_FB_LSB +: 2] = fb_param_q;
            end
            ADDR_LINECNT: rdata_d[LINE_W-1:0] = linecnt_q;
            ADDR_GAIN: rdata_d[GAIN_W-1:0] = gain_q;
            ADDR_STATUS: begin
               rdata_d[ST_DIP_LSB +: DIP_W] = dip;
               rdata_d[ST_ROT_LSB +: ROT_W] = rot_q;
               rdata_d[ST_TORQUE] = torque_q;
               rdata_d[ST_SMART] = smart_q;
               rdata_d[ST_EMUL] = emul_q;
               rdata_d[ST_REJECT] = reject_q;
               rdata_d[ST_HIRES] = hires;
            end
            ADDR_LINES: rdata_d[LINE_W-1:0] = lines_q;
            ADDR_KIP: begin
               rdata_d[GAIN_W-1:0] = store_q ? gout_q : {{(GAIN_W-ROT_W){1'b0}}, gpos_q};
               rdata_d[KIP_STORE_BIT] = store_q;
            end
            default: rdata_d = '0; // Unmapped reads as zero
         endcase
      end
   end

   // Read data flop
   always_ff @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Bus response; every transfer ends OKAY
   assign HREADYOUT_O = (bus_q != BUS_READ_WAIT);
   assign HRESP_O = 1'b0;
   assign HRDATA_O = rdata_q;

   // Decoded settings to the drive, all straight from flops
   assign TORQUE_MODE_O = torque_q;
   assign SMART_FEEDBACK_O = smart_q;
   assign EMUL_ENABLE_O = emul_q;
   assign EMUL_LINES_O = lines_q;
   assign GAIN_POS_O = gpos_q;
   assign GAIN_FROM_STORE_O = store_q;
   assign CURRENT_LOOP_GAIN_O = gout_q;
endmodule

// >>> tb/ssd_switch_panel.sv
// Installer's switch panel: DIP and rotary contacts that bounce after each move.
// Assumes the bench sets the wanted positions; contacts chatter for three cycles.
`timescale 1ns/1ns
module ssd_switch_panel (
   input wire logic clk_i,
   input wire logic [3:0] dip_set_i,
   input wire logic [3:0] rot_set_i,
   output logic [3:0] dip_o,
   output logic [3:0] rot_o
);
   logic [3:0] dip_last = 4'hc; // Reserved positions left closed
   logic [3:0] rot_last = 4'h0;
   logic [1:0] bounce = 2'h0;
   initial dip_o = 4'hc;
   initial rot_o = 4'h0;

   // Chatter alternates with the new position, shorter than the debounce window
   always @(posedge clk_i) begin
      dip_last <= dip_set_i;
      rot_last <= rot_set_i;
      if (dip_set_i != dip_last || rot_set_i != rot_last) begin
         bounce <= 2'h3;
      end else if (bounce != 2'h0) begin
         bounce <= bounce - 2'h1;
      end
      dip_o <= bounce[0] ? ~dip_set_i : dip_set_i;
      rot_o <= bounce[0] ? ~rot_set_i : rot_set_i;
   end
endmodule

// >>> tb/ssd_top_chk.sv
// Checker for the setup switch decoder: bus timing and decoded output relations.
// Assumes it is bound to ssd_top and that HREADY_I is the slave's own HREADYOUT_O.
`timescale 1ns/1ns
module ssd_top_chk #(
   parameter int DEBOUNCE_CYCLES = 4
) (
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   input wire logic [ssd_pkg::DIP_W-1:0] MODE_DIP_SWITCH_I,
   input wire logic [ssd_pkg::ROT_W-1:0] SETUP_ROTARY_SWITCH_I,
   input wire logic HSEL_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic HREADY_I,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   input wire logic TORQUE_MODE_O,
   input wire logic SMART_FEEDBACK_O,
   input wire logic EMUL_ENABLE_O,
   input wire logic [ssd_pkg::LINE_W-1:0] EMUL_LINES_O,
   input wire logic [ssd_pkg::ROT_W-1:0] GAIN_POS_O,
   input wire logic GAIN_FROM_STORE_O,
   input wire logic [ssd_pkg::GAIN_W-1:0] CURRENT_LOOP_GAIN_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);

   // Transfers accepted by the slave
   sequence s_read_taken;
      HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;
   endsequence
   sequence s_write_taken;
      HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I;
   endsequence
   // Smart feedback settled for two cycles, so the later outputs have caught up
   sequence s_smart_held;
      SMART_FEEDBACK_O && $past(SMART_FEEDBACK_O);
   endsequence

   a_read_one_wait: assert property (s_read_taken |=> !HREADYOUT_O ##1 HREADYOUT_O)
      else $error("read wait state not exactly one cycle");
   a_write_no_wait: assert property (s_write_taken |=> HREADYOUT_O)
      else $error("write data phase stalled");
   a_resp_okay: assert property (HRESP_O == 1'b0)
      else $error("response not okay");
   a_emul_with_smart: assert property (s_smart_held |-> EMUL_ENABLE_O)
      else $error("emulated output off in smart feedback");
   a_smart_no_gain: assert property (s_smart_held |-> GAIN_POS_O == 4'h0 && !GAIN_FROM_STORE_O)
      else $error("gain selection active in smart feedback");
   a_store_pos_zero: assert property (GAIN_FROM_STORE_O |-> GAIN_POS_O == 4'h0)
      else $error("stored gain used away from position zero");
   a_gain_only_stored: assert property (!GAIN_FROM_STORE_O |-> CURRENT_LOOP_GAIN_O == 16'h0000)
      else $error("stored gain shown while not selected");
   a_dip_debounced: assert property ($changed(MODE_DIP_SWITCH_I) |=> $stable(TORQUE_MODE_O) [*3])
      else $error("mode output followed an unsettled switch");
   a_rot_debounced: assert property ($changed(SETUP_ROTARY_SWITCH_I) |=> $stable(EMUL_LINES_O) [*3])
      else $error("line count followed an unsettled switch");
endmodule

bind ssd_top ssd_top_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk_u (.REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I),
   .MODE_DIP_SWITCH_I(MODE_DIP_SWITCH_I), .SETUP_ROTARY_SWITCH_I(SETUP_ROTARY_SWITCH_I), .HSEL_I(HSEL_I),
   .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
   .TORQUE_MODE_O(TORQUE_MODE_O), .SMART_FEEDBACK_O(SMART_FEEDBACK_O), .EMUL_ENABLE_O(EMUL_ENABLE_O),
   .EMUL_LINES_O(EMUL_LINES_O), .GAIN_POS_O(GAIN_POS_O), .GAIN_FROM_STORE_O(GAIN_FROM_STORE_O),
   .CURRENT_LOOP_GAIN_O(CURRENT_LOOP_GAIN_O));

// >>> tb/test_setup_switch_decoder.sv
// Bench for the setup switch decoder: switch decoding and parameter registers.
// Assumes a shortened debounce window of 4 cycles and a one-slave AHB-Lite bus.
`timescale 1ns/1ns
module test_setup_switch_decoder;
   import ssd_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hires = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] dip_set = 4'hc;
   logic [3:0] rot_set = 4'h0;
   logic [3:0] dip, rot, gpos;
   logic [31:0] rd, hrdata;
   logic rdy, torque, smart, emul, gstore;
   logic [15:0] lines, gain;
   int err_total = 0;
   int cmp_count = 0;
   logic [15:0] line_tab [0:9] = '{16'h01f4, 16'h0200, 16'h03e8, 16'h0400, 16'h07d0, 16'h0800, 16'h1000,
                                   16'h1388, 16'h2000, 16'h2710};

   // Free-running system clock
   always #10 clk = ~clk;

   ssd_switch_panel panel_u (.clk_i(clk), .dip_set_i(dip_set), .rot_set_i(rot_set), .dip_o(dip), .rot_o(rot));

   ssd_top #(.DEBOUNCE_CYCLES(4)) dut_u (.REF_CLK_I(clk), .RST_B_I(rst_b), .MODE_DIP_SWITCH_I(dip),
      .SETUP_ROTARY_SWITCH_I(rot), .HIRES_OPTION_I(hires), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(rdy), .HREADYOUT_O(rdy), .HRESP_O(),
      .HRDATA_O(hrdata), .TORQUE_MODE_O(torque), .SMART_FEEDBACK_O(smart), .EMUL_ENABLE_O(emul),
      .EMUL_LINES_O(lines), .GAIN_POS_O(gpos), .GAIN_FROM_STORE_O(gstore), .CURRENT_LOOP_GAIN_O(gain));

   task close_out;
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   // Ready is sampled mid-cycle so the edge's own updates never race the bench
   task wait_rdy;
      int n;
      logic r;
      n = 0;
      r = 1'b0;
      while (!r) begin
         @(negedge clk);
         r = rdy;
         rd = hrdata;
         @(posedge clk);
         n++;
         if (n > 20) begin
            err_total++;
            close_out;
         end
      end
   endtask

   // One single word transfer; entered just after a rising edge
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy;
   endtask

   // Move the switches, then allow chatter, sync and debounce to settle
   task sw(input logic [3:0] d, input logic [3:0] r);
      dip_set <= d;
      rot_set <= r;
      repeat (30) @(posedge clk);
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      xfer(1'b0, ADDR_CTRL, 32'h0); chk("ctrl", 32'h0, rd);
      xfer(1'b0, ADDR_LINECNT, 32'h0); chk("linecnt", 32'd500, rd);
      xfer(1'b0, 8'h20, 32'h0); chk("unmapped", 32'h0, rd);
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         sw({~i[1:0], i[1:0]}, 4'h0);
         chk("torque", 32'(i[0]), 32'(torque));
         chk("smart", 32'(i[1]), 32'(smart));
         chk("emul", 32'(i[1]), 32'(emul));
      end
      $display("test mode switch done");
      for (int s = 1; s >= 0; s--) begin
         for (int p = 0; p < 10; p++) begin
            sw({2'h3, s[0], 1'b0}, p[3:0]);
            if (s == 1) begin
               chk("lines", 32'(line_tab[p]), 32'(lines));
            end else begin
               chk("gpos", p, 32'(gpos));
               chk("gstore", 32'(p == 0), 32'(gstore));
               chk("gain", (p == 0) ? 32'h100 : 32'h0, 32'(gain));
            end
         end
      end
      $display("test rotary done");
      sw(4'hc, 4'h0);
      xfer(1'b1, ADDR_GAIN, 32'h0123);
      repeat (5) @(posedge clk);
      chk("gain", 32'h0123, 32'(gain));
      xfer(1'b0, ADDR_GAIN, 32'h0); chk("gain reg", 32'h0123, rd);
      xfer(1'b0, ADDR_KIP, 32'h0); chk("kip", 32'h0001_0123, rd);
      xfer(1'b0, ADDR_LINES, 32'h0); chk("lines reg", 32'd500, rd);
      xfer(1'b0, ADDR_STATUS, 32'h0); chk("status", 32'h0000_000c, rd);
      $display("test stored gain done");
      sw(4'he, 4'h0);
      xfer(1'b1, ADDR_LINECNT, 32'd2500);
      repeat (5) @(posedge clk);
      chk("lines", 32'd2500, 32'(lines));
      xfer(1'b1, ADDR_LINECNT, 32'd300);
      xfer(1'b0, ADDR_LINECNT, 32'h0); chk("linecnt", 32'd2500, rd);
      xfer(1'b0, ADDR_STATUS, 32'h0); chk("reject", 32'h1, 32'(rd[ST_REJECT]));
      sw(4'he, 4'hc);
      chk("lines", 32'd2500, 32'(lines));
      $display("test stored line count done");
      sw(4'hf, 4'h0);
      xfer(1'b1, ADDR_CTRL, 32'ha);
      repeat (5) @(posedge clk);
      chk("torque", 32'h0, 32'(torque));
      chk("smart", 32'h0, 32'(smart));
      chk("emul", 32'h0, 32'(emul));
      hires <= 1'b1;
      sw(4'hc, 4'h0);
      chk("emul", 32'h1, 32'(emul));
      xfer(1'b1, ADDR_CTRL, 32'h5);
      repeat (5) @(posedge clk);
      chk("torque", 32'h1, 32'(torque));
      chk("smart", 32'h1, 32'(smart));
      sw(4'hf, 4'h0);
      xfer(1'b1, ADDR_CTRL, 32'hf);
      repeat (5) @(posedge clk);
      chk("torque", 32'h0, 32'(torque));
      chk("smart", 32'h0, 32'(smart));
      xfer(1'b0, ADDR_CTRL, 32'h0); chk("ctrl", 32'hf, rd);
      $display("test parameter override done");
      close_out;
   end
endmodule
